// >>> logic/stc_pkg.sv
package stc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indexes on the plain register port
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_HOLD = 4'h1;
  localparam logic [3:0] R_DTIME = 4'h2;
  localparam logic [3:0] R_DEVT = 4'h3;
  localparam logic [3:0] R_PWID = 4'h4;
  localparam logic [3:0] R_LEVEL = 4'h5;
  localparam logic [3:0] R_VLINE = 4'h6;
  localparam logic [3:0] R_CMD = 4'h7;
  localparam logic [3:0] R_STAT = 4'h8;

  // Control and level register field positions
  localparam int C_SRC = 0;
  localparam int C_MODE = 3;
  localparam int C_TYPE = 5;
  localparam int C_SLOPE = 8;
  localparam int C_PWC = 10;
  localparam int C_POL = 12;
  localparam int C_STD = 14;
  localparam int C_BYEVT = 16;
  localparam int L_THR = 8;

  // Command register bits, write one to act
  localparam int K_ARM = 0;
  localparam int K_HMIN = 1;
  localparam int K_DMIN = 2;
  localparam int K_LVL50 = 3;
  localparam int K_THR50 = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Sources: comparator vector index equals source code for 0..5
  localparam int NSRC = 6;
  localparam int IX_EXT = 4;
  localparam logic [2:0] SRC_ALT = 3'h6;

  // Field encodings
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam logic [2:0] T_EDGE = 3'h0;
  localparam logic [2:0] T_DELAY = 3'h1;
  localparam logic [2:0] T_PW = 3'h2;
  localparam logic [2:0] T_VIDEO = 3'h3;
  localparam logic [2:0] T_RUNT = 3'h4;
  localparam logic [1:0] SL_RISE = 2'h0;
  localparam logic [1:0] SL_FALL = 2'h1;
  localparam logic [1:0] SL_EITHER = 2'h2;
  localparam logic [1:0] PW_LONGER = 2'h0;
  localparam logic [1:0] PW_SHORTER = 2'h1;
  localparam logic [1:0] PW_EQUAL = 2'h2;
  localparam logic [1:0] POL_POS = 2'h0;
  localparam logic [1:0] POL_NEG = 2'h1;
  localparam logic [1:0] POL_EITHER = 2'h2;
  localparam logic [1:0] STD_NTSC = 2'h0;
  localparam logic [8:0] LINES_NTSC = 9'h107;
  localparam logic [8:0] LINES_PAL = 9'h139;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing, with the cycle counts derived from the 20 MHz clock
  localparam longint CLK_NS = 50;
  localparam longint TMIN_NS = 10;
  localparam longint TMAX_MS = 10000;
  localparam longint AUTO_MS = 100;
  localparam longint HMIN_NS = 10;
  localparam longint TMIN_RAW = (TMIN_NS + CLK_NS - 1) / CLK_NS;
  localparam longint HMIN_RAW = (HMIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [31:0] TMIN_CYC = 32'((TMIN_RAW < 1) ? 1 : TMIN_RAW);
  localparam logic [31:0] HMIN_CYC = 32'((HMIN_RAW < 1) ? 1 : HMIN_RAW);
  localparam logic [31:0] TMAX_CYC = 32'(TMAX_MS * 1000000 / CLK_NS);
  localparam logic [31:0] AUTO_CYC = 32'(AUTO_MS * 1000000 / CLK_NS);
  localparam logic [15:0] EVT_MIN = 16'h0001;
  localparam logic [7:0] RST_LEVEL = 8'h80;
  localparam logic [8:0] RST_VLINE = 9'h001;

  // Delay qualification phases
  typedef enum logic [1:0] {DL_IDLE, DL_TIME, DL_COUNT, DL_READY} stc_dly_e;

endpackage : stc_pkg

// >>> logic/stc_sync.sv
`timescale 1ns/1ps
module stc_sync #(
  parameter int W = 6
) (
  input wire logic ref_clk, // 20 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic [W-1:0] d_in, // Asynchronous levels
  output logic [W-1:0] q // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } stc_sync_s;

  stc_sync_s sync_reg;
  stc_sync_s sync_next;

  // First stage feeds only the second, keeping metastability contained
  always_comb begin
    sync_next.s1 = d_in;
    sync_next.s2 = sync_reg.s1;
  end

  // Two-stage register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= '0;
    end else if (ce) begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.s2;
endmodule : stc_sync

// >>> logic/stc_trigger.sv
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module stc_trigger import stc_pkg::*; #(
  parameter logic [31:0] TIME_MAX_CYC = TMAX_CYC,
  parameter logic [31:0] AUTO_WAIT_CYC = AUTO_CYC
) (
  input wire logic ref_clk, // 20 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic [3:0] addr, // Register index
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd
  input wire logic [5:0] cmp_lo, // Level comparators: ch 0..3, ext, mains
  input wire logic [5:0] cmp_hi, // Upper runt threshold comparators
  input wire logic [7:0] meas_max, // Measured waveform maximum
  input wire logic [7:0] meas_min, // Measured waveform minimum
  output logic trig_out, // Trigger pulse to capture control
  output logic trig_forced, // Trigger was internally forced
  output logic acq_run, // Acquisition enabled
  output logic [7:0] trig_level, // Trigger level to comparator DAC
  output logic [7:0] pw_thresh // Pulse width threshold to DAC
);
  typedef struct packed {
    logic [2:0] src;
    logic [1:0] mode;
    logic [2:0] ttype;
    logic [1:0] slope;
    logic [1:0] pwc;
    logic [1:0] pol;
    logic [1:0] std;
    logic byevt;
    logic [31:0] hold;
    logic [31:0] dtime;
    logic [15:0] devt;
    logic [31:0] pwid;
    logic [7:0] level;
    logic [7:0] thr;
    logic [8:0] vline;
    logic [1:0] alt;
    logic [5:0] plo;
    logic [5:0] phi;
    logic [31:0] hcnt;
    stc_dly_e dph;
    logic [31:0] dcnt;
    logic [31:0] pcnt;
    logic rp;
    logic rph;
    logic rn;
    logic rnh;
    logic [8:0] line;
    logic [31:0] acnt;
    logic armed;
    logic stopped;
    logic trig;
    logic forced;
    logic [31:0] rdata;
  } stc_state_s;

  stc_state_s r;
  stc_state_s n;
  logic [5:0] lo;
  logic [5:0] hi;
  logic [2:0] ix;
  logic s_lo, s_hi, rise, fall, hrise, hfall, sl_evt, ext_rise;
  logic pos, pstart, pend, in_pulse, pw_hit, pw_evt;
  logic [8:0] lmax, nl;
  logic vid_evt, rp_evt, rn_evt, runt_evt, dl_evt;
  logic holding, run, can, real_evt, fire, force_t;
  logic [7:0] half;

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator levels cross into the clock domain first
  stc_sync #(.W(NSRC)) u_sync_lo (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .d_in(cmp_lo), .q(lo));
  stc_sync #(.W(NSRC)) u_sync_hi (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .d_in(cmp_hi), .q(hi));

  // Limits software values to the supported time span
  function automatic logic [31:0] clamp_t(input logic [31:0] v);
    if (v < TMIN_CYC) begin
      clamp_t = TMIN_CYC;
    end else if (v > TIME_MAX_CYC) begin
      clamp_t = TIME_MAX_CYC;
    end else begin
      clamp_t = v;
    end
  endfunction : clamp_t

  ////////////////////////////////////////////////////////////////////////////////
  // Source selection; codes above alternate also rotate, so no index escapes
  assign ix = (r.src >= SRC_ALT) ? {1'b0, r.alt} : r.src;
  assign s_lo = lo[ix];
  assign s_hi = hi[ix];
  assign rise = s_lo & ~r.plo[ix];
  assign fall = ~s_lo & r.plo[ix];
  assign hrise = s_hi & ~r.phi[ix];
  assign hfall = ~s_hi & r.phi[ix];
  assign ext_rise = lo[IX_EXT] & ~r.plo[IX_EXT];
  assign sl_evt = ((r.slope == SL_RISE) & rise) | ((r.slope == SL_FALL) & fall) |
                  ((r.slope == SL_EITHER) & (rise | fall));

  // Pulse polarity: a positive pulse ends on its falling edge
  assign pos = (r.pol == POL_POS);
  assign pstart = pos ? rise : fall;
  assign pend = pos ? fall : rise;
  assign in_pulse = pos ? s_lo : ~s_lo;

  // Width comparison at the end of the pulse
  always_comb begin
    unique case (r.pwc)
      PW_LONGER: pw_hit = r.pcnt > r.pwid;
      PW_SHORTER: pw_hit = r.pcnt < r.pwid;
      PW_EQUAL: pw_hit = r.pcnt == r.pwid;
      default: pw_hit = r.pcnt != r.pwid;
    endcase
  end
  assign pw_evt = pend & pw_hit;

  // Video line count wraps at the field length of the chosen standard
  assign lmax = (r.std == STD_NTSC) ? LINES_NTSC : LINES_PAL;
  assign nl = ((r.line >= lmax) || (r.line == 9'h000)) ? 9'h001 : r.line + 9'h001;
  assign vid_evt = pend & (nl == r.vline);

  // Runt: a positive pulse crossed the low threshold but never the high one, a negative pulse the reverse
  assign rp_evt = fall & r.rp & ~r.rph;
  assign rn_evt = hrise & r.rn & ~r.rnh;
  assign runt_evt = ((r.pol == POL_POS) & rp_evt) | ((r.pol == POL_NEG) & rn_evt) |
                    ((r.pol == POL_EITHER) & (rp_evt | rn_evt));

  // Edge may fire only once the delay phase is complete
  assign dl_evt = sl_evt & ((r.dph == DL_READY) |
                  ((r.dph == DL_COUNT) & (r.dcnt + 32'h0000_0001 == {16'h0000, r.devt})));

  always_comb begin
    unique case (r.ttype)
      T_EDGE: real_evt = sl_evt;
      T_DELAY: real_evt = dl_evt;
      T_PW: real_evt = pw_evt;
      T_VIDEO: real_evt = vid_evt;
      T_RUNT: real_evt = runt_evt;
      default: real_evt = 1'b0;
    endcase
  end

  // Trigger decision: holdoff and single-shot halt gate every type
  assign holding = r.hcnt != 32'h0000_0000;
  assign run = (r.mode != MODE_SINGLE) | r.armed;
  assign can = run & ~holding;
  assign fire = can & real_evt;
  assign force_t = (r.mode == MODE_AUTO) & can & ~real_evt &
                   (r.acnt >= AUTO_WAIT_CYC - 32'h0000_0001);
  assign half = 8'((9'(meas_max) + 9'(meas_min)) >> 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = r;
    n.plo = lo;
    n.phi = hi;
    n.trig = fire | force_t;
    n.forced = force_t;
    n.rdata = 32'h0000_0000;
    // Register reads answer in the following cycle
    if (rd) begin
      unique case (addr)
        R_CTRL: n.rdata = {15'h0000, r.byevt, r.std, r.pol, r.pwc, r.slope, r.ttype, r.mode, r.src};
        R_HOLD: n.rdata = r.hold;
        R_DTIME: n.rdata = r.dtime;
        R_DEVT: n.rdata = {16'h0000, r.devt};
        R_PWID: n.rdata = r.pwid;
        R_LEVEL: n.rdata = {16'h0000, r.thr, r.level};
        R_VLINE: n.rdata = {23'h00_0000, r.vline};
        R_STAT: n.rdata = {15'h0000, r.line, r.dph, r.alt, holding, r.stopped, r.armed, run};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes; delay and width times are clamped at both ends, holdoff and event count only at the low end
    if (wr) begin
      unique case (addr)
        R_CTRL: begin
          n.src = wdata[C_SRC +: 3];
          n.mode = wdata[C_MODE +: 2];
          n.ttype = wdata[C_TYPE +: 3];
          n.slope = wdata[C_SLOPE +: 2];
          n.pwc = wdata[C_PWC +: 2];
          n.pol = wdata[C_POL +: 2];
          n.std = wdata[C_STD +: 2];
          n.byevt = wdata[C_BYEVT];
        end
        R_HOLD: n.hold = (wdata < HMIN_CYC) ? HMIN_CYC : wdata;
        R_DTIME: n.dtime = clamp_t(wdata);
        R_DEVT: n.devt = (wdata[15:0] == 16'h0000) ? EVT_MIN : wdata[15:0];
        R_PWID: n.pwid = clamp_t(wdata);
        R_LEVEL: begin
          n.level = wdata[7:0];
          n.thr = wdata[L_THR +: 8];
        end
        R_VLINE: n.vline = wdata[8:0];
        R_CMD: begin
          if (wdata[K_ARM]) begin
            n.armed = 1'b1;
            n.stopped = 1'b0;
          end
          if (wdata[K_HMIN]) n.hold = HMIN_CYC;
          if (wdata[K_DMIN]) begin
            n.dtime = TMIN_CYC;
            n.devt = EVT_MIN;
          end
          if (wdata[K_LVL50]) n.level = half;
          if (wdata[K_THR50]) n.thr = half;
        end
        default: ;
      endcase
    end
    // Pulse width measurement, saturating for very long pulses
    if (pstart) begin
      n.pcnt = 32'h0000_0001;
    end else if (in_pulse && r.pcnt != 32'hFFFF_FFFF) begin
      n.pcnt = r.pcnt + 32'h0000_0001;
    end
    // Runt tracking for both polarities
    if (rise) begin
      n.rp = 1'b1;
      n.rph = s_hi;
    end else if (r.rp && s_hi) begin
      n.rph = 1'b1;
    end
    if (fall) n.rp = 1'b0;
    if (hfall) begin
      n.rn = 1'b1;
      n.rnh = ~s_lo;
    end else if (r.rn && !s_lo) begin
      n.rnh = 1'b1;
    end
    if (hrise) n.rn = 1'b0;
    // Video line counting
    if (pend && r.ttype == T_VIDEO) n.line = nl;
    // Delay qualification, started by the external input
    unique case (r.dph)
      DL_IDLE: begin
        if (ext_rise && !holding) begin
          n.dcnt = 32'h0000_0000;
          n.dph = r.byevt ? DL_COUNT : DL_TIME;
        end
      end
      DL_TIME: begin
        n.dcnt = r.dcnt + 32'h0000_0001;
        if (r.dcnt + 32'h0000_0001 >= r.dtime) n.dph = DL_READY;
      end
      DL_COUNT: begin
        if (sl_evt) n.dcnt = r.dcnt + 32'h0000_0001;
      end
      DL_READY: ;
    endcase
    if (fire || r.ttype != T_DELAY) n.dph = DL_IDLE;
    // Holdoff countdown, restarted at every trigger point
    if (holding) n.hcnt = r.hcnt - 32'h0000_0001;
    if (fire || force_t) n.hcnt = r.hold;
    // Auto wait counter; it pauses in holdoff rather than restarting
    if (fire || force_t || r.mode != MODE_AUTO) begin
      n.acnt = 32'h0000_0000;
    end else if (can && r.acnt != 32'hFFFF_FFFF) begin
      n.acnt = r.acnt + 32'h0000_0001;
    end
    // Alternate rotation moves on after each trigger
    if ((fire || force_t) && r.src >= SRC_ALT) n.alt = r.alt + 2'h1;
    // A shot in single mode halts; this wins over a rearm in the same cycle
    if (fire && r.mode == MODE_SINGLE) begin
      n.armed = 1'b0;
      n.stopped = 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{dph: DL_IDLE, hold: HMIN_CYC, dtime: TMIN_CYC, devt: EVT_MIN, pwid: TMIN_CYC,
             level: RST_LEVEL, thr: RST_LEVEL, vline: RST_VLINE, default: '0};
    end else if (ce) begin
      r <= n;
    end
  end

  // Outputs
  assign rdata = r.rdata;
  assign trig_out = r.trig;
  assign trig_forced = r.forced;
  assign acq_run = run;
  assign trig_level = r.level;
  assign pw_thresh = r.thr;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_shot;
    ce && r.mode == MODE_SINGLE && fire;
  endsequence

  sequence s_halted;
    r.trig && r.stopped && !acq_run;
  endsequence

  a_single_halt: assert property (s_shot |=> s_halted)
    else $error("single shot did not halt");
  a_stopped_quiet: assert property (r.stopped && r.mode == MODE_SINGLE |-> !fire && !force_t)
    else $error("trigger while halted");
  a_normal_real: assert property (ce && r.mode == MODE_NORMAL && !wr |=> !trig_forced)
    else $error("forced trigger in normal mode");
  a_auto_force: assert property (ce && force_t |-> r.acnt >= AUTO_WAIT_CYC - 1 ##1 trig_out && trig_forced)
    else $error("auto trigger early or lost");
  a_hold_block: assert property (ce && holding |=> !trig_out)
    else $error("trigger inside holdoff");
  a_hold_load: assert property (ce && (fire || force_t) |=> r.hcnt == $past(r.hold))
    else $error("holdoff not restarted");
  a_hold_min: assert property (ce && wr && addr == R_CMD && wdata[K_HMIN] |=> r.hold == HMIN_CYC)
    else $error("holdoff minimum not applied");
  a_delay_first: assert property (r.ttype == T_DELAY && r.dph inside {DL_IDLE, DL_TIME} |-> !real_evt)
    else $error("edge fired before delay done");
  a_slope_rise: assert property (r.ttype == T_EDGE && r.slope == SL_RISE && fire |-> s_lo && !r.plo[ix])
    else $error("rising slope fired on wrong edge");
  a_pw_longer: assert property (r.ttype == T_PW && r.pwc == PW_LONGER && fire |-> r.pcnt > r.pwid)
    else $error("pulse not longer than width");
  a_level_half: assert property (ce && wr && addr == R_CMD && wdata[K_LVL50] |=> r.level == $past(half))
    else $error("level not set to midpoint");
endmodule : stc_trigger

// >>> test/stc_cmp_model.sv
`timescale 1ns/1ps
module stc_cmp_model (
  input wire logic ref_clk, // 20 MHz clock
  output logic [5:0] cmp_lo, // Low threshold comparators
  output logic [5:0] cmp_hi // High threshold comparators
);
  // Idle probes sit below both thresholds
  initial begin
    cmp_lo = 6'h00;
    cmp_hi = 6'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Positive pulse of w cycles on the masked sources, then a quiet tail
  // A runt never reaches the upper threshold, so only the low comparator moves
  task automatic pulse(input logic [5:0] m, input int w, input bit runt);
    @(posedge ref_clk);
    cmp_lo <= cmp_lo | m;
    if (!runt) cmp_hi <= cmp_hi | m;
    repeat (w) @(posedge ref_clk);
    cmp_lo <= cmp_lo & ~m;
    cmp_hi <= cmp_hi & ~m;
    repeat (8) @(posedge ref_clk);
  endtask : pulse
endmodule : stc_cmp_model

// >>> test/test_scope_trigger_condition_logic.sv
`timescale 1ns/1ps
module test_scope_trigger_condition_logic import stc_pkg::*;;
  localparam logic [31:0] TMAX = 32'h40; // Shortened 10 s count
  localparam logic [31:0] AUTOW = 32'h14; // Shortened auto wait
  typedef struct {logic [3:0] a; bit w; logic [31:0] d; logic [31:0] e;} stc_row_s;
  logic ref_clk, arst_n, ce, wr, rd, trig_out, trig_forced, acq_run;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [5:0] cmp_lo, cmp_hi;
  logic [7:0] meas_max, meas_min, trig_level, pw_thresh;
  int err_total, comparisons, n_trig, n_forced, t0;
  logic [1:0] sl [3] = '{SL_RISE, SL_FALL, SL_EITHER};
  int ne [3] = '{1, 1, 2};
  logic [1:0] pc [4] = '{PW_LONGER, PW_SHORTER, PW_EQUAL, 2'h3};
  int e4 [4] = '{0, 1, 0, 1};
  int e16 [4] = '{1, 0, 0, 1};
  int e10 [4] = '{0, 0, 1, 0};
  // Reset values first, then writes with clamping and an unmapped index
  stc_row_s rows [14] = '{'{R_CTRL, 0, 0, 0}, '{R_HOLD, 0, 0, 1}, '{R_DTIME, 0, 0, 1}, '{R_DEVT, 0, 0, 1},
    '{R_PWID, 0, 0, 1}, '{R_VLINE, 0, 0, 1}, '{R_CMD, 0, 0, 0}, '{4'hf, 0, 0, 0}, '{R_DEVT, 1, 0, 1},
    '{R_DTIME, 1, 32'h64, TMAX}, '{R_PWID, 1, 0, 1}, '{4'hc, 1, 5, 0}, '{R_HOLD, 1, 7, 7}, '{R_VLINE, 1, 2, 2}};

  stc_trigger #(.TIME_MAX_CYC(TMAX), .AUTO_WAIT_CYC(AUTOW)) uut (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cmp_lo(cmp_lo), .cmp_hi(cmp_hi),
    .meas_max(meas_max), .meas_min(meas_min), .trig_out(trig_out), .trig_forced(trig_forced),
    .acq_run(acq_run), .trig_level(trig_level), .pw_thresh(pw_thresh));
  stc_cmp_model model (.ref_clk(ref_clk), .cmp_lo(cmp_lo), .cmp_hi(cmp_hi));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and trigger pulse counters
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (trig_out === 1'b1) n_trig++;
    if (trig_forced === 1'b1) n_forced++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : chk_val
  task automatic chk_num(string n, int e, int g);
    comparisons++;
    if (g != e) begin
      $display("Error %s expected %0d seen %0d", n, e, g);
      err_total++;
    end
  endtask : chk_num
  // Bus cycles: one-cycle strobes, read data stands only in the next cycle
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [3:0] a, string n, logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk_val(n, e, rdata);
  endtask : rd_reg
  // One pulse, then the number of triggers it produced
  task automatic fire(logic [5:0] m, int w, bit runt, int e, string n);
    t0 = n_trig;
    model.pulse(m, w, runt);
    chk_num(n, e, n_trig - t0);
  endtask : fire
  function automatic logic [31:0] cw(logic [2:0] s, logic [1:0] m, logic [2:0] t, logic [1:0] l,
                                     logic [1:0] c, logic [1:0] p, logic e);
    cw = (32'(s) << C_SRC) | (32'(m) << C_MODE) | (32'(t) << C_TYPE) | (32'(l) << C_SLOPE);
    cw = cw | (32'(c) << C_PWC) | (32'(p) << C_POL) | (32'(e) << C_BYEVT);
  endfunction : cw

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    meas_max = 8'ha0;
    meas_min = 8'h20;
    repeat (16) @(posedge ref_clk);
    chk_val("trig_level", 32'h80, 32'(trig_level));
    chk_val("pw_thresh", 32'h80, 32'(pw_thresh));
    chk_val("acq_run", 32'h1, 32'(acq_run));
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, "register", rows[i].e);
    end
    // Minimum and midpoint commands together
    wr_reg(R_CMD, 32'h1e);
    rd_reg(R_HOLD, "hold min", HMIN_CYC);
    rd_reg(R_DTIME, "delay min", 32'h1);
    rd_reg(R_DEVT, "event min", 32'h1);
    chk_val("level 50", 32'h60, 32'(trig_level));
    chk_val("thresh 50", 32'h60, 32'(pw_thresh));
    // Auto forces triggers on a quiet input, normal never does
    t0 = n_forced;
    repeat (60) @(posedge ref_clk);
    chk_num("auto forced", 1, int'(n_forced - t0 >= 2));
    wr_reg(R_CTRL, cw(0, MODE_NORMAL, T_EDGE, SL_RISE, 0, 0, 0));
    repeat (8) @(posedge ref_clk);
    t0 = n_trig;
    repeat (60) @(posedge ref_clk);
    chk_num("normal idle", 0, n_trig - t0);
    for (int i = 0; i < 6; i++) begin
      wr_reg(R_CTRL, cw(3'(i), MODE_NORMAL, T_EDGE, SL_RISE, 0, 0, 0));
      fire(6'(1 << ((i + 1) % 6)), 4, 1'b0, 0, "other source");
      fire(6'(1 << i), 4, 1'b0, 1, "source");
    end
    wr_reg(R_CTRL, cw(SRC_ALT, MODE_NORMAL, T_EDGE, SL_RISE, 0, 0, 0));
    fire(6'hf, 4, 1'b0, 1, "alternate");
    // Rotation has moved on to the second channel
    fire(6'h1, 4, 1'b0, 0, "alternate next");
    fire(6'h2, 4, 1'b0, 1, "alternate rotated");
    for (int i = 0; i < 3; i++) begin
      wr_reg(R_CTRL, cw(0, MODE_NORMAL, T_EDGE, sl[i], 0, 0, 0));
      fire(6'h1, 12, 1'b0, ne[i], "slope");
    end
    // Second edge falls inside a long holdoff
    wr_reg(R_HOLD, 32'h28);
    t0 = n_trig;
    model.pulse(6'h1, 2, 1'b0);
    model.pulse(6'h1, 2, 1'b0);
    chk_num("holdoff", 1, n_trig - t0);
    repeat (40) @(posedge ref_clk);
    fire(6'h1, 2, 1'b0, 1, "after holdoff");
    wr_reg(R_HOLD, 32'h1);
    // The running holdoff keeps its old length, so let it run out first
    repeat (40) @(posedge ref_clk);
    // Single shot halts until rearmed
    wr_reg(R_CTRL, cw(0, MODE_SINGLE, T_EDGE, SL_RISE, 0, 0, 0));
    #1 chk_val("single idle", 32'h0, 32'(acq_run));
    wr_reg(R_CMD, 32'h1 << K_ARM);
    #1 chk_val("armed", 32'h1, 32'(acq_run));
    fire(6'h1, 4, 1'b0, 1, "single first");
    chk_val("halted", 32'h0, 32'(acq_run));
    fire(6'h1, 4, 1'b0, 0, "single again");
    // Delay by events: only the third source edge after the external start fires
    wr_reg(R_DEVT, 32'h3);
    wr_reg(R_CTRL, cw(0, MODE_NORMAL, T_DELAY, SL_RISE, 0, 0, 1));
    fire(6'h1, 4, 1'b0, 0, "before start");
    fire(6'h10, 4, 1'b0, 0, "delay start");
    fire(6'h1, 4, 1'b0, 0, "event 1");
    fire(6'h1, 4, 1'b0, 0, "event 2");
    fire(6'h1, 4, 1'b0, 1, "event 3");
    // Delay by time: an edge inside the interval is ignored
    wr_reg(R_DTIME, 32'h1e);
    wr_reg(R_CTRL, cw(0, MODE_NORMAL, T_DELAY, SL_RISE, 0, 0, 0));
    fire(6'h10, 4, 1'b0, 0, "time start");
    fire(6'h1, 4, 1'b0, 0, "inside delay");
    repeat (30) @(posedge ref_clk);
    fire(6'h1, 4, 1'b0, 1, "after delay");
    // Width 10 against pulses of 4, 16 and 10, judged at the falling end
    wr_reg(R_PWID, 32'ha);
    for (int i = 0; i < 4; i++) begin
      wr_reg(R_CTRL, cw(0, MODE_NORMAL, T_PW, 0, pc[i], POL_POS, 0));
      fire(6'h1, 4, 1'b0, e4[i], "short pulse");
      fire(6'h1, 16, 1'b0, e16[i], "long pulse");
      fire(6'h1, 10, 1'b0, e10[i], "equal pulse");
    end
    // Video: each sync end counts a line, the second line matches
    wr_reg(R_CTRL, cw(0, MODE_NORMAL, T_VIDEO, 0, 0, POL_POS, 0));
    fire(6'h1, 4, 1'b0, 0, "video line 1");
    fire(6'h1, 4, 1'b0, 1, "video line 2");
    wr_reg(R_CTRL, cw(0, MODE_NORMAL, T_RUNT, 0, 0, POL_POS, 0));
    fire(6'h1, 4, 1'b1, 1, "runt");
    fire(6'h1, 4, 1'b0, 0, "full pulse");
    wr_reg(R_CTRL, cw(0, MODE_NORMAL, T_RUNT, 0, 0, POL_NEG, 0));
    fire(6'h1, 4, 1'b1, 0, "runt negative");
    wr_reg(R_CTRL, cw(0, MODE_NORMAL, T_RUNT, 0, 0, POL_EITHER, 0));
    fire(6'h1, 4, 1'b1, 1, "runt either");
    // Strobes are ignored while the clock enable is low
    @(posedge ref_clk);
    ce <= 1'b0;
    wr_reg(R_HOLD, 32'h5);
    ce <= 1'b1;
    rd_reg(R_HOLD, "frozen", 32'h1);
    // Reset in mid-run brings back the defaults
    @(posedge ref_clk);
    arst_n <= 1'b0;
    @(posedge ref_clk);
    arst_n <= 1'b1;
    chk_val("reset level", 32'h80, 32'(trig_level));
    chk_val("reset thresh", 32'h80, 32'(pw_thresh));
    rd_reg(R_CTRL, "reset ctrl", 32'h0);
    give_verdict();
  end
endmodule : test_scope_trigger_condition_logic
